/* hdl/tts_map.svh */
// Purpose: Offsets, field positions, reset values for the thermal
//          throttle control and trip status registers.
// Assumes: Byte-addressed memory-mapped window, 16-bit data path.
// Notes:   Definitions only.
`ifndef TTS_MAP_SVH
`define TTS_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TTS_OFS_CTRL        16'h101c
`define TTS_OFS_STAT        16'h101e

// ****************************************************************
// Control register fields
// ****************************************************************
`define TTS_CTRL_LOCK_BIT   0
`define TTS_CTRL_HALT_BIT   3
`define TTS_CTRL_ZONE_BIT   4
`define TTS_CTRL_MEN_BIT    7
`define TTS_CTRL_WMASK      8'h98
`define TTS_CTRL_RESET      8'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define TTS_STAT_FALL_LSB   8
`define TTS_STAT_RISE_LSB   0
`define TTS_STAT_RISE_MASK  16'h003f
`define TTS_STAT_FALL_MASK  16'h3f00
`define TTS_STAT_RESET      16'h0000

// ****************************************************************
// Trip indices inside a six-bit event vector
// ****************************************************************
`define TTS_TRIP_AUX2       2
`define TTS_TRIP_HOT        4
`define TTS_TRIP_CRIT       5

`endif

/* hdl/tts_pkg.sv */
// Purpose: Types shared by the thermal throttle and trip status block.
// Assumes: Six trip points: aux0..aux3, hot, critical.
// Notes:   Constants live in tts_map.svh.
package tts_pkg;

    // Register bus request from the host core.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0]  be;
    } tts_req_t;

    // Per-trip comparator levels, index 0 aux0 .. 5 critical.
    typedef logic [5:0] tts_trip_t;

    // Shutdown latch states.
    typedef enum logic [1:0] {
        TTS_RUN  = 2'b01,
        TTS_HALT = 2'b10
    } tts_halt_st_t;

endpackage : tts_pkg

/* hdl/tts_edge.sv */
// Purpose: Edge detector for the six trip comparator levels.
// Assumes: Levels arrive from the sensor comparator on clk.
// Notes:   No synchroniser; the comparator shares the core clock.
`timescale 1ns/100ps
`default_nettype none
module tts_edge (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire tts_pkg::tts_trip_t above,
    output wire tts_pkg::tts_trip_t rise,
    output wire tts_pkg::tts_trip_t fall
);
    import tts_pkg::*;

    tts_trip_t above_ff;

    // ****************************************************************
    // Previous level
    // ****************************************************************
    // Reset to zero so a trip already high at release counts as rising.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            above_ff <= 6'h00;
        end else begin
            above_ff <= above;
        end
    end

    // One-cycle pulses per trip point.
    genvar gi;
    for (gi = 0; gi < 6; gi++) begin : g_edge
        assign rise[gi] = above[gi] & ~above_ff[gi];
        assign fall[gi] = ~above[gi] & above_ff[gi];
    end

endmodule : tts_edge
`default_nettype wire

/* hdl/tts_regs.sv */
// Purpose: Thermal throttle control register, trip status register
//          and latched thermal shutdown output.
// Assumes: Single-cycle register access on the core clock; comparator
//          levels are synchronous to clk.
// Notes:   Reads return data one cycle after rd.
`timescale 1ns/100ps
`default_nettype none
`include "tts_map.svh"
module tts_regs (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire tts_pkg::tts_req_t  req,
    input  wire tts_pkg::tts_trip_t trip_above,
    output var  logic [15:0]        rdata,
    output var  logic               rvalid,
    output logic                    throttle_req,
    output logic                    thermal_event,
    output var  logic               thermal_shutdown_out_n
);
    import tts_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]   ctrl_ff;
    logic [7:0]   nxt_ctrl;
    logic [15:0]  stat_ff;
    logic [15:0]  nxt_stat;
    logic [15:0]  rdata_ff;
    logic [15:0]  nxt_rdata;
    logic         rvalid_ff;
    tts_halt_st_t halt_ff;
    tts_halt_st_t nxt_halt;
    tts_trip_t    rise;
    tts_trip_t    fall;

    wire          hit_ctrl;
    wire          hit_stat;
    wire          wr_ctrl;
    wire          wr_stat_lo;
    wire          wr_stat_hi;
    wire [15:0]   stat_set;
    wire [15:0]   stat_clr;
    wire [15:0]   stat_wmask;
    wire          lock;
    wire          master_en;
    wire          zone_sel;
    wire          halt_en;
    wire          zone_hit;
    wire          crit_now;

    // ****************************************************************
    // Crossing detection
    // ****************************************************************
    tts_edge u_edge (
        .clk   (clk),
        .rst_b (rst_b),
        .above (trip_above),
        .rise  (rise),
        .fall  (fall)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // The control register is a byte; only lane 0 reaches it.
    assign hit_ctrl   = (req.addr == `TTS_OFS_CTRL);
    assign hit_stat   = (req.addr == `TTS_OFS_STAT);
    assign wr_ctrl    = req.wr & hit_ctrl & req.be[0];
    assign wr_stat_lo = req.wr & hit_stat & req.be[0];
    assign wr_stat_hi = req.wr & hit_stat & req.be[1];

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    assign lock      = ctrl_ff[`TTS_CTRL_LOCK_BIT];
    assign master_en = ctrl_ff[`TTS_CTRL_MEN_BIT];
    assign zone_sel  = ctrl_ff[`TTS_CTRL_ZONE_BIT];
    assign halt_en   = ctrl_ff[`TTS_CTRL_HALT_BIT];

    // Next control value.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            if (!lock) begin
                nxt_ctrl = req.wdata[7:0] & `TTS_CTRL_WMASK;
            end
            nxt_ctrl[`TTS_CTRL_LOCK_BIT] = lock | req.wdata[0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_ff <= `TTS_CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ****************************************************************
    // Throttle request
    // ****************************************************************
    // Zone choice.
    assign zone_hit = trip_above[`TTS_TRIP_HOT]
                    | trip_above[`TTS_TRIP_CRIT]
                    | (~zone_sel & trip_above[`TTS_TRIP_AUX2]);
    assign throttle_req = master_en & zone_hit;

    // ****************************************************************
    // Trip status register
    // ****************************************************************
    // Rise flags in bits 5:0, fall flags in bits 13:8.
    assign stat_set = {2'b00, fall, 2'b00, rise};

    assign stat_wmask = {{8{wr_stat_hi}}, {8{wr_stat_lo}}};
    assign stat_clr   = req.wdata & stat_wmask;

    assign nxt_stat = ((stat_ff & ~stat_clr) | stat_set)
                    & (`TTS_STAT_RISE_MASK | `TTS_STAT_FALL_MASK);

    // Sticky flags hold until software clears them with a one.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_ff <= `TTS_STAT_RESET;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    assign thermal_event = |stat_ff;

    // ****************************************************************
    // Thermal shutdown latch
    // ****************************************************************
    // Critical level this cycle, so shutdown does not wait for an edge.
    assign crit_now = trip_above[`TTS_TRIP_CRIT];

    always_comb begin
        case (halt_ff)
            TTS_RUN: begin
                nxt_halt = (halt_en & crit_now) ? TTS_HALT : TTS_RUN;
            end
            TTS_HALT: begin
                nxt_halt = TTS_HALT;
            end
            default: begin
                nxt_halt = TTS_HALT;
            end
        endcase
    end

    // An illegal state falls to halt, the safe side for a thermal trip.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            halt_ff                <= TTS_RUN;
            thermal_shutdown_out_n <= 1'b1;
        end else begin
            halt_ff                <= nxt_halt;
            thermal_shutdown_out_n <= (nxt_halt != TTS_HALT);
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Unmapped addresses read zero; reads have no side effects.
    always_comb begin
        nxt_rdata = 16'h0000;
        if (req.rd && hit_ctrl) begin
            nxt_rdata = {8'h00, ctrl_ff};
        end else if (req.rd && hit_stat) begin
            nxt_rdata = stat_ff;
        end
    end

    // Registered read data, valid the cycle after rd.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_ff  <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= req.rd;
        end
    end

    assign rdata  = rdata_ff;
    assign rvalid = rvalid_ff;

endmodule : tts_regs
`default_nettype wire

/* verif/tts_regs_sva.sv */
// Purpose: Port-level checks for the thermal trip register block.
// Assumes: Trip levels are held low across every reset.
// Notes:   Bound into tts_regs after the module.
`timescale 1ns/100ps
`default_nettype none
module tts_regs_sva (
    input wire logic               clk,
    input wire logic               rst_b,
    input wire tts_pkg::tts_req_t  req,
    input wire tts_pkg::tts_trip_t trip_above,
    input wire logic [15:0]        rdata,
    input wire logic               rvalid,
    input wire logic               throttle_req,
    input wire logic               thermal_event,
    input wire logic               thermal_shutdown_out_n
);
    import tts_pkg::*;
    // ****************************************************************
    // Read steps and checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // A read is taken at one edge and answered at the next.
    sequence s_rd_ctrl;
        req.rd && req.addr == 16'h101c;
    endsequence
    sequence s_rd_stat;
        req.rd && req.addr == 16'h101e;
    endsequence
    ctrl_fields_a: assert property (s_rd_ctrl |=> rvalid &&
        (rdata & 16'hff66) == 16'h0000) else $error("ctrl spare set");
    stat_resv_a: assert property (s_rd_stat |=> rvalid &&
        rdata[15:14] == 2'b00) else $error("status spare set");
    shut_hold_a: assert property (!thermal_shutdown_out_n |=>
        !thermal_shutdown_out_n) else $error("shutdown released");
    shut_cause_a: assert property ($fell(thermal_shutdown_out_n) |->
        $past(trip_above[5])) else $error("shutdown without trip");
    zone_hit_a: assert property (throttle_req |->
        (trip_above & 6'h34) != 6'h00) else $error("throttle no zone");
    crit_rise_a: assert property ($rose(trip_above[5]) ##1
        s_rd_stat |=> rdata[5]) else $error("crit rise lost");
    crit_fall_a: assert property ($fell(trip_above[5]) ##1
        s_rd_stat |=> rdata[13]) else $error("crit fall lost");
    event_flag_a: assert property ($changed(trip_above) |=>
        thermal_event) else $error("event flag missing");
    w1c_clear_a: assert property (req.wr && req.addr == 16'h101e &&
        req.be == 2'b11 && req.wdata == 16'h3f3f && !$changed(trip_above)
        |=> !thermal_event) else $error("status not cleared");
endmodule : tts_regs_sva
bind tts_regs tts_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .req(req),
    .trip_above(trip_above), .rdata(rdata), .rvalid(rvalid),
    .throttle_req(throttle_req), .thermal_event(thermal_event),
    .thermal_shutdown_out_n(thermal_shutdown_out_n));
`default_nettype wire

/* verif/tts_regs_tb.sv */
// Purpose: Self-checking bench for the thermal trip register block.
// Assumes: Inputs change on the falling edge; reads answer one cycle on.
// Notes:   Trip levels are returned low before any reset.
`timescale 1ns/100ps
`default_nettype none
module tts_regs_tb;
    import tts_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    tts_req_t    req = '0;
    tts_trip_t   trip_above = '0;
    logic [15:0] rdata;
    logic        rvalid;
    logic        throttle_req;
    logic        thermal_event;
    logic        thermal_shutdown_out_n;
    int          num_errors = 0;
    int          checks_done = 0;
    logic [15:0] e;
    always #12.5 clk = ~clk;
    tts_regs dut (.clk(clk), .rst_b(rst_b), .req(req),
        .trip_above(trip_above), .rdata(rdata), .rvalid(rvalid),
        .throttle_req(throttle_req), .thermal_event(thermal_event),
        .thermal_shutdown_out_n(thermal_shutdown_out_n));
    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input string w, input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", w, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, d, input logic [1:0] b);
        @(negedge clk);
        req = '{1'b1, 1'b0, a, d, b};
        @(negedge clk);
        req = '0;
    endtask : wr
    // Read data stands one cycle only, so it is judged right then.
    task automatic rd(input logic [15:0] a, exp, input string w);
        @(negedge clk);
        req = '{1'b0, 1'b1, a, 16'h0000, 2'b00};
        @(negedge clk);
        req = '0;
        chk("rvalid", {15'h0000, rvalid}, 16'h0001);
        chk(w, rdata, exp);
    endtask : rd
    task automatic tp(input tts_trip_t v);
        @(negedge clk);
        trip_above = v;
        #1;
    endtask : tp
    task automatic do_reset();
        @(negedge clk);
        rst_b = 1'b0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
    endtask : do_reset
    task automatic test_done();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd(16'h101c, 16'h0000, "ctrl");
        rd(16'h101e, 16'h0000, "stat");
        wr(16'h1020, 16'hffff, 2'b11);
        rd(16'h1020, 16'h0000, "unmapped");
        rd(16'h101c, 16'h0000, "ctrl after stray");
    endtask : t_reset
    task automatic t_throttle();
        wr(16'h101c, 16'h0080, 2'b01);
        tp(6'h04);
        chk("thr aux2", throttle_req, 1'b1);
        wr(16'h101c, 16'h0090, 2'b01);
        chk("thr aux2 z1", throttle_req, 1'b0);
        tp(6'h10);
        chk("thr hot z1", throttle_req, 1'b1);
        wr(16'h101c, 16'h0010, 2'b01);
        chk("thr off", throttle_req, 1'b0);
        tp(6'h00);
        wr(16'h101e, 16'h3f3f, 2'b11);
    endtask : t_throttle
    // Every trip index rises then falls; each flag is cleared by a one.
    task automatic t_status();
        for (int i = 0; i < 6; i++) begin
            e = 16'h0001 << i;
            tp(e[5:0]);
            rd(16'h101e, e, "rise flag");
            chk("event", thermal_event, 1'b1);
            tp(6'h00);
            e = e | (e << 8);
            rd(16'h101e, e, "fall flag");
            wr(16'h101e, 16'h0000, 2'b11);
            rd(16'h101e, e, "zero write");
            wr(16'h101e, 16'h3f3f, 2'b11);
            rd(16'h101e, 16'h0000, "cleared");
            chk("event idle", thermal_event, 1'b0);
        end
    endtask : t_status
    task automatic t_race();
        tp(6'h01);
        tp(6'h00);
        @(negedge clk);
        req = '{1'b1, 1'b0, 16'h101e, 16'h0101, 2'b11};
        trip_above = 6'h01;
        @(negedge clk);
        req = '0;
        rd(16'h101e, 16'h0001, "set wins");
        tp(6'h00);
        wr(16'h101e, 16'h3f3f, 2'b11);
    endtask : t_race
    task automatic t_halt_lock();
        wr(16'h101c, 16'h0008, 2'b01);
        tp(6'h20);
        @(negedge clk);
        chk("shutdown", thermal_shutdown_out_n, 1'b0);
        tp(6'h00);
        @(negedge clk);
        chk("shutdown held", thermal_shutdown_out_n, 1'b0);
        wr(16'h101c, 16'h00ff, 2'b01);
        rd(16'h101c, 16'h0099, "ctrl locked");
        wr(16'h101c, 16'h0000, 2'b01);
        rd(16'h101c, 16'h0099, "lock holds");
        // Zone bit was written one; the locked zero write must not clear it.
        rd(16'h101c, 16'h0099, "zone locked");
        do_reset();
        chk("shutdown free", thermal_shutdown_out_n, 1'b1);
        rd(16'h101c, 16'h0000, "lock reset");
    endtask : t_halt_lock
    initial begin
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_throttle();
        t_status();
        t_race();
        t_halt_lock();
        test_done();
    end
    // Watchdog so that a hang still reaches the verdict.
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule : tts_regs_tb
`default_nettype wire
